//--- tppc_pin_sync.sv
// Three-stage synchroniser with edge pulses for an asynchronous pin.
// Assumes the pin is slow compared with the 20 MHz clock.
`timescale 1ns/1ps
module tppc_pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_r; // First stage, read only by the second
  logic s2_r; // Second stage
  logic s3_r; // Third stage
  wire agree_w = (s2_r == s3_r); // Stable once stages two and three match
  // Shift chain, accept a level once two stages agree
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rise <= agree_w && s3_r && !level;
      fall <= agree_w && !s3_r && level;
      if (agree_w) begin
        level <= s3_r;
      end
    end
  end
endmodule

//--- tppc_pkg.sv
// Constants, offsets and reset values for the timer, PWM and port control bank.
// Assumes a single 20 MHz clock and an Avalon-MM master with 32-bit data.
// Operation
// - Edge bit: clear rising, set falling interrupt
// - Global flag read-only; instructions set/clear it
// - Source bit picks instruction cycles or pin
// - Pin edge bit picks rising or falling count
// - Prescaler off gives 1:1, on uses field
// - Prescale field divides 1:2 up to 1:256
// - Free timer times out after 256 counts
// - Direction bit zero drives, one floats pin
// - PWM enable takes shared pin, forces output
// - Line 3 owner: reference, PWM, then port
// - PWM control bit 4 reads zero
// - PWM timer run bits start, stop, reset clear
// - PWM prescale codes map 1:1 to 1:256
// - PWM prescale fields sit at stated bits
// - Comparator bit 2 reads result, 7:3 zero
// - Comparator mode field selects pin function
// - Port 6 line 0 owner: output, converter, port
// - Pull-down bit zero enables, one disables
package tppc_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] TPPC_OFS_TCC_CFG = 8'h00;
  localparam logic [7:0] TPPC_OFS_P5_DIR = 8'h04;
  localparam logic [7:0] TPPC_OFS_P6_DIR = 8'h08;
  localparam logic [7:0] TPPC_OFS_P7_DIR = 8'h0C;
  localparam logic [7:0] TPPC_OFS_PWM_CFG = 8'h10;
  localparam logic [7:0] TPPC_OFS_TMR_CFG = 8'h14;
  localparam logic [7:0] TPPC_OFS_CMP_CFG = 8'h18;
  localparam logic [7:0] TPPC_OFS_PD_CTRL = 8'h1C;
  localparam logic [7:0] TPPC_OFS_TCC_CNT = 8'h20;
  // Reset values
  localparam logic [7:0] TPPC_RST_TCC_CFG = 8'h00;
  localparam logic [7:0] TPPC_RST_DIR = 8'hFF;
  localparam logic [7:0] TPPC_RST_PWM_CFG = 8'h00;
  localparam logic [7:0] TPPC_RST_TMR_CFG = 8'h00;
  localparam logic [1:0] TPPC_RST_CMP_MODE = 2'h0;
  localparam logic [7:0] TPPC_RST_PD_CTRL = 8'hFF;
  localparam logic [7:0] TPPC_RST_CNT = 8'h00;
  // Field positions in the timer and interrupt config register
  localparam int TPPC_BIT_IRQ_EDGE = 7;
  localparam int TPPC_BIT_GIE = 6;
  localparam int TPPC_BIT_TS = 5;
  localparam int TPPC_BIT_TE = 4;
  localparam int TPPC_BIT_FREE_TIMER_PRESCALER_ON = 3;
  // Field positions in the PWM channel register
  localparam int TPPC_BIT_PWM3_ON = 7;
  localparam int TPPC_BIT_PWM2_ON = 6;
  localparam int TPPC_BIT_PWM1_ON = 5;
  localparam int TPPC_BIT_PWM_RSVD = 4;
  localparam int TPPC_BIT_T1_RUN = 3;
  // Field positions in the PWM timer two/three register, then the comparator result bit
  localparam int TPPC_BIT_T3_RUN = 7;
  localparam int TPPC_BIT_T2_RUN = 6;
  localparam int TPPC_LSB_T3_PRE = 3;
  localparam int TPPC_LSB_T2_PRE = 0;
  localparam int TPPC_BIT_CMP_RES = 2;
  // Last free timer count before the wrap, in prescaled counts
  localparam logic [7:0] TPPC_TCC_LAST = 8'hFF;
  // Comparator modes
  typedef enum logic [1:0] {
    TPPC_CMP_OFF = 2'h0,
    TPPC_CMP_ON = 2'h1,
    TPPC_CMP_PIN = 2'h2,
    TPPC_AMP_PIN = 2'h3
  } tppc_cmp_mode_t;
  // Owner of a shared pin
  typedef enum logic [1:0] {
    TPPC_OWN_PORT = 2'h0,
    TPPC_OWN_PERIPH = 2'h1,
    TPPC_OWN_ANALOG = 2'h2
  } tppc_owner_t;
endpackage

//--- tppc_prescaler.sv
// Power-of-two event divider: one tick per 2**ratio_log2 input events.
// Assumes evt is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module tppc_prescaler (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic evt,
  input wire logic [3:0] ratio_log2,
  output logic tick
);
  logic [7:0] cnt_r; // Event count
  wire [8:0] mask_w = (9'h001 << ratio_log2) - 9'h001; // Low bits in use
  wire last_w = ((cnt_r & mask_w[7:0]) == mask_w[7:0]); // Last event of a group
  // Count events, tick on the last one of each group
  always_ff @(posedge clk) begin
    if (!rst_b || clear) begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end else begin
      tick <= evt && last_w;
      if (evt) begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

//--- tppc_regs.sv
// Control bank for free timer, external interrupt edge, ports, PWM and comparator.
// Assumes an Avalon-MM master on clk and pulse inputs from the CPU core.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tppc_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic instr_cycle_en,
  input wire logic irq_mask_instr,
  input wire logic irq_unmask_instr,
  input wire logic irq_return_instr,
  input wire logic hw_irq_entry,
  output logic global_irq_enable,
  input wire logic ext_irq_pin,
  output logic ext_irq_event,
  input wire logic tcc_count_pin,
  output logic tcc_timeout,
  output logic [2:0] pwm_timer_tick,
  input wire logic [2:0] pwm_wave,
  input wire logic vref_select,
  input wire logic adc_input_zero,
  input wire logic comparator_result,
  output logic comparator_on,
  output logic amplifier_on,
  input wire logic [7:0] port5_data,
  input wire logic [7:0] port6_data,
  input wire logic [7:0] port7_data,
  output logic [7:0] port5_o,
  output logic [7:0] port5_oe,
  output logic [7:0] port6_o,
  output logic [7:0] port6_oe,
  output logic [7:0] port7_o,
  output logic [7:0] port7_oe,
  output logic [1:0] port5_line3_owner,
  output logic [1:0] port6_line0_owner,
  output logic [7:0] port6_pull_down_on
);
  import tppc_pkg::*;

  // Prescale code of a PWM timer to log2 of its ratio
  function automatic logic [3:0] pwm_pre_log2(input logic [2:0] code);
    logic [3:0] r;
    r = {1'b0, code};
    if (code > 3'h4) begin
      r = {1'b0, code} + 4'h1;
    end
    return r;
  endfunction

  // Control registers
  logic ext_irq_edge_select_r; // Interrupt edge select
  logic gie_r; // Global interrupt flag
  logic tcc_source_select_r; // Free timer source
  logic count_pin_edge_select_r; // Count pin edge
  logic free_timer_prescaler_on_r; // Free timer prescaler on
  logic [2:0] free_timer_prescale_sel_r; // Free timer prescale code
  logic [7:0] port5_dir_r; // Port 5 direction
  logic [7:0] port6_dir_r; // Port 6 direction
  logic [7:0] port7_dir_r; // Port 7 direction
  logic [7:0] pwm_cfg_r; // PWM channel register, bit 4 held zero
  logic [7:0] tmr_cfg_r; // PWM timer two/three register
  logic [1:0] comparator_mode_sel_r; // Comparator mode field
  logic [7:0] pull_down_disable_n_r; // Active-low pull-down enables
  logic [7:0] free_count_r; // Free timer count
  logic ack_r; // Bus answer cycle
  logic [31:0] rdata_r; // Read data flop

  // Bus handshake: one wait cycle per access
  wire req_w = read || write;
  assign waitrequest = req_w && !ack_r;
  assign readdata = rdata_r;
  wire wr_en_w = write && ack_r && byteenable[0]; // Write lands on the ack edge
  wire [7:0] wd_w = writedata[7:0];

  // Address decode
  wire sel_cfg_w = (address == TPPC_OFS_TCC_CFG);
  wire sel_p5_w = (address == TPPC_OFS_P5_DIR);
  wire sel_p6_w = (address == TPPC_OFS_P6_DIR);
  wire sel_p7_w = (address == TPPC_OFS_P7_DIR);
  wire sel_pwm_w = (address == TPPC_OFS_PWM_CFG);
  wire sel_tmr_w = (address == TPPC_OFS_TMR_CFG);
  wire sel_cmp_w = (address == TPPC_OFS_CMP_CFG);
  wire sel_pd_w = (address == TPPC_OFS_PD_CTRL);
  wire sel_cnt_w = (address == TPPC_OFS_TCC_CNT);

  // Synchronised analog comparator result
  logic cmp_level_w;
  tppc_pin_sync u_cmp_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(comparator_result),
    .level(cmp_level_w),
    .rise(),
    .fall()
  );

  // Register images for read back
  wire [7:0] cfg_img_w = {ext_irq_edge_select_r, gie_r, tcc_source_select_r,
    count_pin_edge_select_r, free_timer_prescaler_on_r, free_timer_prescale_sel_r};
  wire [7:0] cmp_img_w = {5'h00, cmp_level_w, comparator_mode_sel_r};

  // Read mux, unmapped reads return zero
  wire [7:0] rmux_w =
    sel_cfg_w ? cfg_img_w :
    sel_p5_w ? port5_dir_r :
    sel_p6_w ? port6_dir_r :
    sel_p7_w ? port7_dir_r :
    sel_pwm_w ? pwm_cfg_r :
    sel_tmr_w ? tmr_cfg_r :
    sel_cmp_w ? cmp_img_w :
    sel_pd_w ? pull_down_disable_n_r :
    sel_cnt_w ? free_count_r : 8'h00;

  // Bus answer and read capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_w && !ack_r;
      if (read && !ack_r) begin
        rdata_r <= {24'h000000, rmux_w};
      end
    end
  end

  // Software-written registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_irq_edge_select_r <= TPPC_RST_TCC_CFG[TPPC_BIT_IRQ_EDGE];
      tcc_source_select_r <= TPPC_RST_TCC_CFG[TPPC_BIT_TS];
      count_pin_edge_select_r <= TPPC_RST_TCC_CFG[TPPC_BIT_TE];
      free_timer_prescaler_on_r <= TPPC_RST_TCC_CFG[TPPC_BIT_FREE_TIMER_PRESCALER_ON];
      free_timer_prescale_sel_r <= TPPC_RST_TCC_CFG[2:0];
      port5_dir_r <= TPPC_RST_DIR;
      port6_dir_r <= TPPC_RST_DIR;
      port7_dir_r <= TPPC_RST_DIR;
      pwm_cfg_r <= TPPC_RST_PWM_CFG;
      tmr_cfg_r <= TPPC_RST_TMR_CFG;
      comparator_mode_sel_r <= TPPC_RST_CMP_MODE;
      pull_down_disable_n_r <= TPPC_RST_PD_CTRL;
    end else if (wr_en_w) begin
      if (sel_cfg_w) begin // Global flag bit is not written
        ext_irq_edge_select_r <= wd_w[TPPC_BIT_IRQ_EDGE];
        tcc_source_select_r <= wd_w[TPPC_BIT_TS];
        count_pin_edge_select_r <= wd_w[TPPC_BIT_TE];
        free_timer_prescaler_on_r <= wd_w[TPPC_BIT_FREE_TIMER_PRESCALER_ON];
        free_timer_prescale_sel_r <= wd_w[2:0];
      end else if (sel_p5_w) begin
        port5_dir_r <= wd_w;
      end else if (sel_p6_w) begin
        port6_dir_r <= wd_w;
      end else if (sel_p7_w) begin
        port7_dir_r <= wd_w;
      end else if (sel_pwm_w) begin // Bit 4 forced zero
        pwm_cfg_r <= wd_w & ~(8'h01 << TPPC_BIT_PWM_RSVD);
      end else if (sel_tmr_w) begin
        tmr_cfg_r <= wd_w;
      end else if (sel_cmp_w) begin
        comparator_mode_sel_r <= wd_w[1:0];
      end else if (sel_pd_w) begin
        pull_down_disable_n_r <= wd_w;
      end
    end
  end

  // Global interrupt flag: set by unmask or return, cleared by mask or interrupt entry, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gie_r <= 1'b0;
    end else if (irq_unmask_instr || irq_return_instr) begin
      gie_r <= 1'b1;
    end else if (irq_mask_instr || hw_irq_entry) begin
      gie_r <= 1'b0;
    end
  end
  assign global_irq_enable = gie_r;

  // External interrupt pin edge detection
  logic irq_rise_w;
  logic irq_fall_w;
  logic irq_level_w; // Settled pin level, watched by the edge check
  tppc_pin_sync u_irq_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_irq_pin),
    .level(irq_level_w),
    .rise(irq_rise_w),
    .fall(irq_fall_w)
  );
  wire irq_edge_w = ext_irq_edge_select_r ? irq_fall_w : irq_rise_w;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_irq_event <= 1'b0;
    end else begin
      ext_irq_event <= irq_edge_w;
    end
  end

  // Free timer source and edge
  logic cnt_rise_w;
  logic cnt_fall_w;
  tppc_pin_sync u_cnt_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin(tcc_count_pin),
    .level(),
    .rise(cnt_rise_w),
    .fall(cnt_fall_w)
  );
  wire pin_evt_w = count_pin_edge_select_r ? cnt_fall_w : cnt_rise_w;
  wire tcc_evt_w = tcc_source_select_r ? pin_evt_w : instr_cycle_en;
  // Prescale off is 1:1, on is 1:2 .. 1:256
  wire [3:0] tcc_log2_w = free_timer_prescaler_on_r ?
    ({1'b0, free_timer_prescale_sel_r} + 4'h1) : 4'h0;
  logic tcc_tick_w;
  tppc_prescaler u_tcc_pre (
    .clk(clk),
    .rst_b(rst_b),
    .clear(1'b0),
    .evt(tcc_evt_w),
    .ratio_log2(tcc_log2_w),
    .tick(tcc_tick_w)
  );

  // Free timer count, timeout after 256 prescaled counts
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      free_count_r <= TPPC_RST_CNT;
      tcc_timeout <= 1'b0;
    end else begin
      tcc_timeout <= tcc_tick_w && (free_count_r == TPPC_TCC_LAST);
      if (tcc_tick_w) begin
        free_count_r <= free_count_r + 8'h01;
      end
    end
  end

  // PWM timer run bits and prescale fields
  wire [2:0] pwm_run_w = {tmr_cfg_r[TPPC_BIT_T3_RUN], tmr_cfg_r[TPPC_BIT_T2_RUN],
    pwm_cfg_r[TPPC_BIT_T1_RUN]};
  wire [2:0] pwm_code_w [3];
  assign pwm_code_w[0] = pwm_cfg_r[2:0];
  assign pwm_code_w[1] = tmr_cfg_r[TPPC_LSB_T2_PRE +: 3];
  assign pwm_code_w[2] = tmr_cfg_r[TPPC_LSB_T3_PRE +: 3];

  // One prescaler per PWM timer, held clear while stopped
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pwm_pre
      tppc_prescaler u_pre (
        .clk(clk),
        .rst_b(rst_b),
        .clear(!pwm_run_w[gi]),
        .evt(instr_cycle_en && pwm_run_w[gi]),
        .ratio_log2(pwm_pre_log2(pwm_code_w[gi])),
        .tick(pwm_timer_tick[gi])
      );
    end
  endgenerate

  // Shared pin ownership
  wire [2:0] pwm_on_w = {pwm_cfg_r[TPPC_BIT_PWM3_ON], pwm_cfg_r[TPPC_BIT_PWM2_ON],
    pwm_cfg_r[TPPC_BIT_PWM1_ON]};
  wire cmp_pin_w = comparator_mode_sel_r[1]; // Modes 10 and 11 drive the pin
  // Port 5 line 3: reference first, then PWM three, then port
  wire [1:0] p53_own_w = vref_select ? TPPC_OWN_ANALOG :
    pwm_on_w[2] ? TPPC_OWN_PERIPH : TPPC_OWN_PORT;
  // Port 6 line 0: comparator output, then converter, then port
  wire [1:0] p60_own_w = cmp_pin_w ? TPPC_OWN_PERIPH :
    adc_input_zero ? TPPC_OWN_ANALOG : TPPC_OWN_PORT;
  // Comparator output level for mode 10; amplifier output is analog
  wire co_level_w = (comparator_mode_sel_r == TPPC_CMP_PIN) && cmp_level_w;

  // Port 5 next values; PWM lines 1..3 on pins 1..3
  logic [7:0] p5_o_nxt;
  logic [7:0] p5_oe_nxt;
  always_comb begin
    p5_o_nxt = port5_data;
    p5_oe_nxt = ~port5_dir_r;
    p5_o_nxt[2:1] = pwm_on_w[1:0] & pwm_wave[1:0] | ~pwm_on_w[1:0] & port5_data[2:1];
    p5_oe_nxt[2:1] = pwm_on_w[1:0] | ~port5_dir_r[2:1];
    if (p53_own_w == TPPC_OWN_ANALOG) begin
      p5_o_nxt[3] = 1'b0;
      p5_oe_nxt[3] = 1'b0;
    end else if (p53_own_w == TPPC_OWN_PERIPH) begin
      p5_o_nxt[3] = pwm_wave[2];
      p5_oe_nxt[3] = 1'b1;
    end
  end

  // Port 6 next values
  logic [7:0] p6_o_nxt;
  logic [7:0] p6_oe_nxt;
  always_comb begin
    p6_o_nxt = port6_data;
    p6_oe_nxt = ~port6_dir_r;
    if (p60_own_w == TPPC_OWN_PERIPH) begin
      p6_o_nxt[0] = co_level_w;
      p6_oe_nxt[0] = 1'b1;
    end else if (p60_own_w == TPPC_OWN_ANALOG) begin
      p6_o_nxt[0] = 1'b0;
      p6_oe_nxt[0] = 1'b0;
    end
  end

  // Pin and status output flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port5_o <= 8'h00;
      port5_oe <= 8'h00;
      port6_o <= 8'h00;
      port6_oe <= 8'h00;
      port7_o <= 8'h00;
      port7_oe <= 8'h00;
      port5_line3_owner <= TPPC_OWN_PORT;
      port6_line0_owner <= TPPC_OWN_PORT;
      port6_pull_down_on <= 8'h00;
      comparator_on <= 1'b0;
      amplifier_on <= 1'b0;
    end else begin
      port5_o <= p5_o_nxt;
      port5_oe <= p5_oe_nxt;
      port6_o <= p6_o_nxt;
      port6_oe <= p6_oe_nxt;
      port7_o <= port7_data;
      port7_oe <= ~port7_dir_r;
      port5_line3_owner <= p53_own_w;
      port6_line0_owner <= p60_own_w;
      port6_pull_down_on <= ~pull_down_disable_n_r;
      comparator_on <= (comparator_mode_sel_r == TPPC_CMP_ON) ||
        (comparator_mode_sel_r == TPPC_CMP_PIN);
      amplifier_on <= (comparator_mode_sel_r == TPPC_AMP_PIN);
    end
  end

  // Checks
  a_gie_set: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_unmask_instr || irq_return_instr) |=> global_irq_enable)
    else $error("global flag not set by unmask or return");
  a_gie_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_mask_instr && !irq_unmask_instr && !irq_return_instr) |=> !global_irq_enable)
    else $error("global flag not cleared by mask");
  a_gie_ro: assert property (@(posedge clk) disable iff (!rst_b)
    (!irq_unmask_instr && !irq_return_instr && !irq_mask_instr && !hw_irq_entry)
    |=> $stable(global_irq_enable))
    else $error("global flag changed without instruction");
  a_irq_edge: assert property (@(posedge clk) disable iff (!rst_b)
    ext_irq_event |-> ($past(irq_level_w) != $past(ext_irq_edge_select_r)))
    else $error("interrupt on wrong edge");
  a_tcc_wrap: assert property (@(posedge clk) disable iff (!rst_b)
    tcc_timeout |-> (free_count_r == 8'h00) && $past(free_count_r) == 8'hFF)
    else $error("timeout not at count wrap");
  a_tcc_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (!tcc_source_select_r && !instr_cycle_en) [*3] |=> $stable(free_count_r))
    else $error("free timer moved without source event");
  a_pwm_stop: assert property (@(posedge clk) disable iff (!rst_b)
    (!pwm_run_w[0]) [*2] |-> !pwm_timer_tick[0])
    else $error("stopped PWM timer ticked");
  a_pwm_pin: assert property (@(posedge clk) disable iff (!rst_b)
    (pwm_on_w[0] && !$changed(pwm_on_w[0])) |=> port5_oe[1])
    else $error("PWM pin not forced to output");
  a_vref_own: assert property (@(posedge clk) disable iff (!rst_b)
    vref_select |=> (port5_line3_owner == TPPC_OWN_ANALOG) && !port5_oe[3])
    else $error("reference did not win line 3");
  a_co_own: assert property (@(posedge clk) disable iff (!rst_b)
    (comparator_mode_sel_r[1] && adc_input_zero) |=> port6_oe[0])
    else $error("comparator output lost line 0");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !pwm_cfg_r[TPPC_BIT_PWM_RSVD] && (cmp_img_w[7:3] == 5'h00))
    else $error("reserved bit not zero");
  a_bus_wait: assert property (@(posedge clk) disable iff (!rst_b)
    (req_w && waitrequest) |=> !waitrequest)
    else $error("bus waited more than one cycle");
  c_timeout: cover property (@(posedge clk) disable iff (!rst_b) tcc_timeout);
  c_ext_irq: cover property (@(posedge clk) disable iff (!rst_b) ext_irq_event);
  c_pwm_tick: cover property (@(posedge clk) disable iff (!rst_b) pwm_timer_tick[2]);
  c_co_pin: cover property (@(posedge clk) disable iff (!rst_b)
    port6_line0_owner == TPPC_OWN_PERIPH);
endmodule

//--- tppc_regs_tb.sv
// Self-checking bench for the timer, PWM and port control bank.
// Assumes tppc_pkg and the bank, with its own assertions, are compiled first.
`timescale 1ns/1ps
module tppc_regs_tb;
  import tppc_pkg::*;
  logic clk, rst_b, read, write, waitrequest, instr_cycle_en, hw_irq_entry;
  logic irq_mask_instr, irq_unmask_instr, irq_return_instr, global_irq_enable;
  logic ext_irq_pin, ext_irq_event, tcc_count_pin, tcc_timeout, vref_select;
  logic adc_input_zero, comparator_result, comparator_on, amplifier_on;
  logic [7:0] address, port5_data, port6_data, port7_data, port5_o, port5_oe;
  logic [7:0] port6_o, port6_oe, port7_o, port7_oe, port6_pull_down_on, rv;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [2:0] pwm_timer_tick, pwm_wave;
  logic [1:0] port5_line3_owner, port6_line0_owner;
  logic [15:0] seed = 16'hDC10;  // Xorshift state, 56336
  logic [31:0] exp_q[$];  // Expected read data, oldest first
  int fails = 0, cmp_count = 0;
  logic [7:0] to_cnt = 8'h00, ev_cnt = 8'h00, tk_cnt = 8'h00;  // Event counts
  // Bank under test
  tppc_regs i_tppc_regs (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .instr_cycle_en(instr_cycle_en),
    .irq_mask_instr(irq_mask_instr), .irq_unmask_instr(irq_unmask_instr),
    .irq_return_instr(irq_return_instr), .hw_irq_entry(hw_irq_entry),
    .global_irq_enable(global_irq_enable), .ext_irq_pin(ext_irq_pin),
    .ext_irq_event(ext_irq_event), .tcc_count_pin(tcc_count_pin),
    .tcc_timeout(tcc_timeout), .pwm_timer_tick(pwm_timer_tick), .pwm_wave(pwm_wave),
    .vref_select(vref_select), .adc_input_zero(adc_input_zero),
    .comparator_result(comparator_result), .comparator_on(comparator_on),
    .amplifier_on(amplifier_on), .port5_data(port5_data), .port6_data(port6_data),
    .port7_data(port7_data), .port5_o(port5_o), .port5_oe(port5_oe), .port6_o(port6_o),
    .port6_oe(port6_oe), .port7_o(port7_o), .port7_oe(port7_oe),
    .port5_line3_owner(port5_line3_owner), .port6_line0_owner(port6_line0_owner),
    .port6_pull_down_on(port6_pull_down_on));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Next pseudo-random byte
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed[7:0];
  endfunction
  // Verdict and end of run
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Read data comparison
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Pin level comparison, after outputs have settled
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    address <= a;
    writedata <= {24'h000000, d};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    bus(1'b0, a, 8'h00, 4'h1);
  endtask
  // Instruction cycle pulses, then settle time
  task automatic instr(input int n);
    repeat (n) begin
      @(posedge clk) instr_cycle_en <= 1'b1;
      @(posedge clk) instr_cycle_en <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  // Count pin pulses with sync time
  task automatic cpin(input int n);
    repeat (n) begin
      @(posedge clk) tcc_count_pin <= 1'b1;
      repeat (6) @(posedge clk);
      tcc_count_pin <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  // Watches completed reads and matches them to the oldest note
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        cmp_rd(readdata, 32'hFFFFFFFF);
      end else begin
        cmp_rd(readdata, exp_q.pop_front());
      end
    end
    if (tcc_timeout === 1'b1) to_cnt++;
    if (ext_irq_event === 1'b1) ev_cnt++;
    if (pwm_timer_tick[0] === 1'b1) tk_cnt++;
  end
  // Hang guard
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [7:0] msk[8] = '{8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'h03, 8'hFF};
    logic [7:0] rst[8] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF};
    logic [3:0] gv[4] = '{4'b0100, 4'b0001, 4'b0010, 4'b1000};
    {rst_b, read, write, instr_cycle_en, hw_irq_entry, irq_mask_instr} = '0;
    {irq_unmask_instr, irq_return_instr, ext_irq_pin, tcc_count_pin} = '0;
    {vref_select, adc_input_zero, comparator_result, address, writedata} = '0;
    byteenable = 4'h0;
    {port5_data, port6_data, port7_data} = {rnd(), rnd(), rnd()};
    pwm_wave = 3'(rnd());
    {port5_data[7], port7_data[0]} = 2'b00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(offs[i], rst[i]);
    // Free timer on instruction cycles, 1:1 then 1:2 and 1:256
    instr(255);
    rd(8'h20, 8'hFF);
    instr(1);
    chk(to_cnt, 8'h01);
    wr(8'h00, 8'h08);
    instr(4);
    rd(8'h20, 8'h02);
    wr(8'h00, 8'h0F);
    instr(256);
    rd(8'h20, 8'h03);
    // Count pin, rising then falling edges
    wr(8'h00, 8'h20);
    cpin(3);
    rd(8'h20, 8'h06);
    wr(8'h00, 8'h30);
    cpin(2);
    rd(8'h20, 8'h08);
    // External interrupt edge
    wr(8'h00, 8'h00);
    ext_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'h00, 8'h80);
    ext_irq_pin <= 1'b1;
    repeat (8) @(posedge clk);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(ev_cnt, 8'h02);
    // PWM timer one: run 1:1, stop, then 1:64
    wr(8'h10, 8'h08);
    instr(5);
    chk(tk_cnt, 8'h05);
    wr(8'h10, 8'h00);
    instr(3);
    chk(tk_cnt, 8'h05);
    wr(8'h10, 8'h0D);
    instr(128);
    chk(tk_cnt, 8'h07);
    // Direction, PWM pin takeover and reference priority
    wr(8'h04, 8'h0F);
    repeat (2) @(posedge clk);
    chk(port5_oe, 8'hF0);
    chk(port7_oe, 8'h00);
    chk(port7_o, port7_data);
    wr(8'h10, 8'hA0);
    repeat (2) @(posedge clk);
    chk(port5_oe, 8'hFA);
    rv = {port5_data[7:4], pwm_wave[2], port5_data[2], pwm_wave[0], port5_data[0]};
    chk(port5_o, rv);
    chk({6'h00, port5_line3_owner}, 8'h01);
    wr(8'h10, 8'h20);
    vref_select <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h00, port5_line3_owner}, 8'h02);
    // Comparator modes with the converter claiming the pin
    adc_input_zero <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, m[7:0]);
      repeat (3) @(posedge clk);
      rv = {4'h0, (m >= 2) ? 2'h1 : 2'h2, m == 1 || m == 2, m == 3};
      chk({4'h0, port6_line0_owner, comparator_on, amplifier_on}, rv);
      chk(port6_oe, {7'h00, m >= 2});
    end
    comparator_result <= 1'b1;
    wr(8'h18, 8'hF9);
    repeat (6) @(posedge clk);
    rd(8'h18, 8'h05);
    // Pull-down polarity
    rv = rnd();
    wr(8'h1C, rv);
    repeat (3) @(posedge clk);
    chk(port6_pull_down_on, ~rv);
    // Random write and read back of every writable register, masked bits stay zero
    comparator_result <= 1'b0;
    vref_select <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rv = rnd();
      wr(offs[i], rv);
      repeat (6) @(posedge clk);
      rd(offs[i], rv & msk[i]);
    end
    wr(8'h04, 8'h5A);
    bus(1'b1, 8'h04, 8'h33, 4'h0);
    rd(8'h04, 8'h5A);
    wr(8'h24, 8'h5A);
    rd(8'h24, 8'h00);
    // Global flag set and cleared by core pulses
    wr(8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {irq_mask_instr, irq_unmask_instr, irq_return_instr, hw_irq_entry} <= gv[i];
      @(posedge clk);
      {irq_mask_instr, irq_unmask_instr, irq_return_instr, hw_irq_entry} <= 4'h0;
      repeat (2) @(posedge clk);
      chk({7'h00, global_irq_enable}, {7'h00, gv[i][2] | gv[i][1]});
      rd(8'h00, {1'b0, gv[i][2] | gv[i][1], 6'h00});
    end
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule
